// >>> sdrx_ctrl.sv
// controller end: apb registers, init, single-word access, refresh
// assumes apb master on pclk; memory end on the same clock
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module sdrx_ctrl #(
  parameter int INIT_CYCLES = 16,
  parameter int REFRESH_GAP = sdrx_pkg::REFRESH_GAP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  sdrx_link_if.host        link
);
  typedef enum logic [3:0] {
    ST_INIT = 4'h0, ST_PRE_ALL = 4'h1, ST_LOAD = 4'h2, ST_IDLE = 4'h3, ST_ACT = 4'h4,
    ST_HOLD = 4'h5, ST_PRE = 4'h6, ST_REF = 4'h7, ST_SELF = 4'h8, ST_WAKE = 4'h9
  } sdrx_state_t;

  sdrx_state_t         state;
  sdrx_state_t         next_state;
  sdrx_pkg::sdrx_cmd_t cmd_q;
  sdrx_pkg::sdrx_cmd_t next_cmd;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [2:0]  op;
  logic [22:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [11:0] mode_reg;
  logic [15:0] ref_cnt;
  logic        ref_due;
  logic [11:0] next_a;
  logic [1:0]  next_ba;
  logic [1:0]  next_dqm;
  logic        next_oe_n;
  logic        next_cke;
  logic        op_done;
  logic        ref_take;

  wire        acc = psel && penable;
  wire [7:0]  off = paddr[7:0];
  wire        mapped = paddr[31:8] == 24'h0 && (off == sdrx_pkg::REG_CTRL ||
                off == sdrx_pkg::REG_ADDR || off == sdrx_pkg::REG_WDATA ||
                off == sdrx_pkg::REG_RDATA || off == sdrx_pkg::REG_STATUS ||
                off == sdrx_pkg::REG_MODE);
  wire        wr_hit = acc && pwrite && mapped;
  wire        busy = state != ST_IDLE || op != sdrx_pkg::OP_NONE;
  wire        ctrl_ok = op == sdrx_pkg::OP_NONE && ((state == ST_SELF) ==
                (pwdata[2:0] == sdrx_pkg::OP_WAKE));
  wire [31:0] status = {29'h0, ref_due, state == ST_SELF, busy};
  wire [31:0] rd_mux = (off == sdrx_pkg::REG_CTRL) ? {29'h0, op} :
                       (off == sdrx_pkg::REG_ADDR) ? {9'h0, addr_reg} :
                       (off == sdrx_pkg::REG_WDATA) ? {16'h0, wdata_reg} :
                       (off == sdrx_pkg::REG_RDATA) ? {16'h0, rdata_reg} :
                       (off == sdrx_pkg::REG_STATUS) ? status :
                       (off == sdrx_pkg::REG_MODE) ? {20'h0, mode_reg} : 32'h0;
  // capture point follows the chosen latency
  wire [2:0]  lat = mode_reg[sdrx_pkg::CL_LSB +: 3];
  wire [9:0]  beats = sdrx_pkg::burst_beats(mode_reg[sdrx_pkg::BL_LSB +: 3]);
  // hold the row past its open minimum
  wire [11:0] hold_lim = 12'(beats) + 12'(lat) + 12'(sdrx_pkg::ROW_OPEN_MIN_CYC);
  // row on all lines, column on the low ones
  wire [11:0] row_a = addr_reg[20:9];
  wire [11:0] col_a = {3'h0, addr_reg[8:0]};
  wire        is_wr = op == sdrx_pkg::OP_WRITE;

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 12'h001;
    next_cmd = sdrx_pkg::CMD_NOP;
    next_a = link.mux_address_bus;
    next_ba = link.bank_select;
    next_dqm = 2'h0;
    next_oe_n = 1'b1;
    next_cke = link.cke;
    op_done = 1'b0;
    ref_take = 1'b0;
    unique case (state)
      ST_INIT: begin
        if (cnt == 12'(INIT_CYCLES)) begin
          next_state = ST_PRE_ALL;
          next_cmd = sdrx_pkg::CMD_PRECHARGE;
          next_a = 12'h400;
        end
      end
      ST_PRE_ALL: begin
        if (cnt == 12'(sdrx_pkg::PRECHARGE_CYC - 1)) begin
          next_state = ST_LOAD;
          next_cmd = sdrx_pkg::CMD_MODE;
          next_a = mode_reg;
        end
      end
      ST_LOAD: begin
        if (cnt == 12'(sdrx_pkg::MODE_WAIT_CYC - 1)) begin
          next_state = ST_IDLE;
          op_done = 1'b1;
        end
      end
      ST_IDLE: begin
        if (ref_due) begin
          next_state = ST_REF;
          next_cmd = sdrx_pkg::CMD_REFRESH;
          ref_take = 1'b1;
        end else if (is_wr || op == sdrx_pkg::OP_READ) begin
          next_state = ST_ACT;
          next_cmd = sdrx_pkg::CMD_ACTIVATE;
          next_a = row_a;
          next_ba = addr_reg[22:21];
        end else if (op == sdrx_pkg::OP_MODE) begin
          next_state = ST_LOAD;
          next_cmd = sdrx_pkg::CMD_MODE;
          next_a = mode_reg;
        end else if (op == sdrx_pkg::OP_SLEEP) begin
          next_state = ST_SELF;
          next_cmd = sdrx_pkg::CMD_REFRESH;
          next_cke = 1'b0;
          op_done = 1'b1;
        end else begin
          next_cnt = 12'h000;
        end
      end
      ST_ACT: begin
        if (cnt == 12'(sdrx_pkg::ACT_TO_ACCESS_CYC - 1)) begin
          next_state = ST_HOLD;
          next_cmd = is_wr ? sdrx_pkg::CMD_WRITE : sdrx_pkg::CMD_READ;
          next_a = col_a;
          next_oe_n = !is_wr;
        end
      end
      ST_HOLD: begin
        next_dqm = {2{is_wr}};
        if (cnt == hold_lim) begin
          next_state = ST_PRE;
          next_cmd = sdrx_pkg::CMD_PRECHARGE;
          next_a = 12'h400;
        end
      end
      ST_PRE: begin
        if (cnt == 12'(sdrx_pkg::AFTER_PRE_CYC - 1)) begin
          next_state = ST_IDLE;
          op_done = 1'b1;
        end
      end
      ST_REF: begin
        if (cnt == 12'(sdrx_pkg::ROW_CYCLE_CYC - 1)) begin
          next_state = ST_IDLE;
        end
      end
      ST_SELF: begin
        next_cke = 1'b0;
        if (op == sdrx_pkg::OP_WAKE) begin
          next_state = ST_WAKE;
          next_cke = 1'b1;
        end
      end
      ST_WAKE: begin
        // enable high well before next command
        if (cnt == 12'(sdrx_pkg::ROW_CYCLE_CYC - 1)) begin
          next_state = ST_IDLE;
          op_done = 1'b1;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
    if (next_state != state) begin
      next_cnt = 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_INIT;
      cnt <= 12'h000;
      cmd_q <= sdrx_pkg::CMD_NOP;
      link.cke <= 1'b1;
      link.mux_address_bus <= 12'h000;
      link.bank_select <= 2'h0;
      {link.high_byte_mask, link.low_byte_mask} <= 2'h3;
      link.host_dq_oe_n <= 1'b1;
      link.host_dq_out <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cmd_q <= next_cmd;
      link.cke <= next_cke;
      link.mux_address_bus <= next_a;
      link.bank_select <= next_ba;
      {link.high_byte_mask, link.low_byte_mask} <= next_dqm;
      link.host_dq_oe_n <= next_oe_n;
      link.host_dq_out <= wdata_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= sdrx_pkg::OP_NONE;
      addr_reg <= 23'h0;
      wdata_reg <= 16'h0000;
      mode_reg <= sdrx_pkg::MODE_RESET;
      prdata <= 32'h0;
    end else begin
      if (op_done) begin
        op <= sdrx_pkg::OP_NONE;
      end else if (wr_hit && off == sdrx_pkg::REG_CTRL && ctrl_ok) begin
        op <= pwdata[2:0];
      end
      if (wr_hit && off == sdrx_pkg::REG_ADDR && !busy) begin
        addr_reg <= pwdata[22:0];
      end
      if (wr_hit && off == sdrx_pkg::REG_WDATA && !busy) begin
        wdata_reg <= pwdata[15:0];
      end
      if (wr_hit && off == sdrx_pkg::REG_MODE && !busy) begin
        mode_reg <= pwdata[11:0];
      end
      if (psel && !penable) begin
        prdata <= rd_mux;
      end
    end
  end

  // sample first beat at the latency edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 16'h0000;
    end else if (state == ST_HOLD && !is_wr && cnt == 12'(lat)) begin
      rdata_reg <= link.shared_data_bus;
    end
  end

  // refresh due flag, set wins over take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 16'h0000;
      ref_due <= 1'b0;
    end else if (ref_cnt == 16'(REFRESH_GAP - 1)) begin
      ref_cnt <= 16'h0000;
      ref_due <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 16'h0001;
      if (ref_take) begin
        ref_due <= 1'b0;
      end
    end
  end
endmodule

// >>> sdrx_device.sv
// memory end: four banks of 16-bit words, commands sampled on the rising edge
// assumes the controller keeps row timing and refresh spacing
//
// Overview of operation
// - read data appears two or three cycles later
// - bursts of 1, 2, 4, 8 or page
// - sequential or interleaved burst order
// - burst writes or single-word writes
// - all inputs sampled on rising clock edge
// - deselected: only clock, enable, masks act
// - enable low freezes state from next cycle
// - controller raises enable before next command
// - row uses MUX_ADDRESS_BUS, column low lines
// - bank pins pick bank for row/column
// - row strobe latches row, opens, precharges
// - column strobe latches column for access
// - write enable: writes, precharge, data capture
// - byte masks: read hi-z, write block
// - one shared bidirectional sixteen-bit data bus
// - controller refreshes 4K rows per 64ms
// - auto refresh and self refresh supported
// - activate to access wait, 18/20 ns
// - bank to bank activate gap
// - 12-bit rows, 9-bit columns, four banks
// - 2097152 words per bank
`timescale 1ns/1ps
module sdrx_device #(
  parameter int STORE_AW = sdrx_pkg::FULL_AW
) (
  input wire logic    pclk,
  input wire logic    presetn,
  sdrx_link_if.device link
);
  localparam int DEPTH = 2 ** STORE_AW;

  logic        cke_q;
  logic        in_self;
  logic [11:0] mode_reg;
  logic [3:0]  row_open;
  logic [11:0] row_addr [0:3];
  logic        bst_on;
  logic        bst_wr;
  logic [1:0]  bst_bank;
  logic [8:0]  bst_start;
  logic [8:0]  bst_idx;
  logic [15:0] p0;
  logic [15:0] p1;
  logic        p0_v;
  logic        p1_v;
  logic [15:0] q_out;
  logic [1:0]  dqm_q;
  logic [1:0]  oe_n;
  logic [15:0] mem [0:DEPTH-1];

  // clock masked one cycle after enable falls
  wire run = cke_q;
  wire live = run && !in_self;

  // command decode from select and strobes
  wire sdrx_pkg::sdrx_cmd_t cmd = sdrx_pkg::sdrx_cmd_t'({link.cs_n, link.ras_n,
                                                        link.cas_n, link.we_n});
  wire sel = !link.cs_n;
  wire do_mode = live && sel && cmd == sdrx_pkg::CMD_MODE;
  wire do_ref = live && sel && cmd == sdrx_pkg::CMD_REFRESH;
  wire do_act = live && sel && cmd == sdrx_pkg::CMD_ACTIVATE;
  wire do_pre = live && sel && cmd == sdrx_pkg::CMD_PRECHARGE;
  wire do_rd = live && sel && cmd == sdrx_pkg::CMD_READ;
  wire do_wr = live && sel && cmd == sdrx_pkg::CMD_WRITE;
  wire do_stop = live && sel && cmd == sdrx_pkg::CMD_STOP;

  wire [1:0]  ba = link.bank_select;
  // column on the low address lines
  wire [8:0]  col_in = link.mux_address_bus[sdrx_pkg::COL_W-1:0];
  wire        pre_all = link.mux_address_bus[sdrx_pkg::PRE_ALL_BIT];
  wire        bank_ok = row_open[ba];
  wire        start_rd = do_rd && bank_ok;
  wire        start_wr = do_wr && bank_ok;

  wire [2:0]  bl = mode_reg[sdrx_pkg::BL_LSB +: 3];
  wire        ilv = mode_reg[sdrx_pkg::BT_BIT];
  wire [2:0]  wr_bl = mode_reg[sdrx_pkg::WB_BIT] ? 3'h0 : bl;
  wire        lat3 = mode_reg[sdrx_pkg::CL_LSB +: 3] == sdrx_pkg::CL_THREE;

  wire [2:0]  cur_bl = bst_wr ? wr_bl : bl;
  wire [9:0]  cur_beats = sdrx_pkg::burst_beats(cur_bl);
  wire [2:0]  new_bl = start_wr ? wr_bl : bl;
  wire [9:0]  new_beats = sdrx_pkg::burst_beats(new_bl);
  wire [8:0]  bst_col = sdrx_pkg::burst_col(bst_start, bst_idx, cur_bl, ilv);
  wire        kill_pre = do_pre && (pre_all || ba == bst_bank);
  wire        cont = live && bst_on && !do_stop && !kill_pre && !start_rd && !start_wr;
  wire        last = (cur_bl != sdrx_pkg::BL_FULL) && ({1'b0, bst_idx} == cur_beats - 10'h001);

  wire [1:0]  acc_bank = cont ? bst_bank : ba;
  wire [11:0] acc_row = row_addr[acc_bank];
  wire [8:0]  acc_col = cont ? bst_col : col_in;
  // row, bank, column index the storage
  wire [STORE_AW-1:0] acc_idx = STORE_AW'({acc_row, acc_bank, acc_col});
  wire        rd_beat = start_rd || (cont && !bst_wr);
  wire        wr_beat = start_wr || (cont && bst_wr);
  wire [1:0]  mask_in = {link.high_byte_mask, link.low_byte_mask};

  wire [15:0] q_next = lat3 ? p1 : p0;
  wire        q_v_next = lat3 ? p1_v : p0_v;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= link.cke;
    end
  end

  // self refresh entered with enable low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_self <= 1'b0;
    end else if (do_ref && !link.cke) begin
      in_self <= 1'b1;
    end else if (in_self && run) begin
      in_self <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= sdrx_pkg::MODE_RESET;
    end else if (do_mode) begin
      mode_reg <= link.mux_address_bus;
    end
  end

  // four banks each holding one open row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_open <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        row_addr[b] <= 12'h000;
      end
    end else if (do_act && !bank_ok) begin
      row_open[ba] <= 1'b1;
      row_addr[ba] <= link.mux_address_bus;
    end else if (do_pre && pre_all) begin
      row_open <= 4'h0;
    end else if (do_pre) begin
      row_open[ba] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_on <= 1'b0;
      bst_wr <= 1'b0;
      bst_bank <= 2'h0;
      bst_start <= 9'h000;
      bst_idx <= 9'h000;
    end else if (start_rd || start_wr) begin
      bst_on <= new_beats > 10'h001;
      bst_wr <= start_wr;
      bst_bank <= ba;
      bst_start <= col_in;
      bst_idx <= 9'h001;
    end else if (cont) begin
      bst_on <= !last;
      bst_idx <= bst_idx + 9'h001;
    end else if (live && bst_on) begin
      bst_on <= 1'b0;
    end
  end

  // data taken from the command cycle on
  always_ff @(posedge pclk) begin
    if (wr_beat && !mask_in[0]) begin
      mem[acc_idx][7:0] <= link.shared_data_bus[7:0];
    end
    if (wr_beat && !mask_in[1]) begin
      mem[acc_idx][15:8] <= link.shared_data_bus[15:8];
    end
  end

  // read pipeline, two or three stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0 <= 16'h0000;
      p1 <= 16'h0000;
      p0_v <= 1'b0;
      p1_v <= 1'b0;
      q_out <= 16'h0000;
    end else if (run) begin
      p0 <= mem[acc_idx];
      p0_v <= rd_beat;
      p1 <= p0;
      p1_v <= p0_v;
      q_out <= q_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dqm_q <= 2'h0;
      oe_n <= 2'h3;
    end else if (run) begin
      dqm_q <= mask_in;
      oe_n <= ~({2{q_v_next}} & ~dqm_q);
    end
  end

  // one word a cycle on the shared pins
  assign link.dev_dq_out = q_out;
  assign link.dev_dq_oe_n = oe_n;
endmodule

// >>> sdrx_link_assertions.sv
// concurrent checks on the controller to memory link pins
// assumes instantiation in tb_top beside the link interface
`timescale 1ns/1ps
module sdrx_link_assertions (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       low_byte_mask,
  input wire logic       high_byte_mask,
  input wire logic       host_dq_oe_n,
  input wire logic [1:0] dev_dq_oe_n
);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire       act = cmd == sdrx_pkg::CMD_ACTIVATE;
  wire       wr  = cmd == sdrx_pkg::CMD_WRITE;
  wire       acc = wr || cmd == sdrx_pkg::CMD_READ;
  wire       pre = cmd == sdrx_pkg::CMD_PRECHARGE;
  wire       rfr = cmd == sdrx_pkg::CMD_REFRESH;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_write_data_on:
    assert property (wr |-> !host_dq_oe_n && !low_byte_mask && !high_byte_mask)
    else $error("write without data drive");
  chk_write_one_word:
    assert property (wr |=> host_dq_oe_n && low_byte_mask && high_byte_mask)
    else $error("later write beat not masked");
  chk_bus_no_fight:
    assert property (!(!host_dq_oe_n && dev_dq_oe_n != 2'b11))
    else $error("both ends drive data");
  chk_act_to_access:
    assert property (act |=> !acc [*4])
    else $error("access too soon after activate");
  chk_bank_gap:
    assert property (act |=> !act [*3])
    else $error("activates too close");
  chk_precharge_gap:
    assert property (pre |=> !act [*4])
    else $error("activate too soon after precharge");
  chk_cke_before_cmd:
    assert property (!cs_n && cmd != sdrx_pkg::CMD_NOP |-> $past(cke))
    else $error("command without prior enable");
  chk_refresh_quiet:
    assert property (rfr && cke |=> (!act && !acc) [*8])
    else $error("command too soon after refresh");
  cover property (wr);
  cover property (cmd == sdrx_pkg::CMD_READ);
  cover property ($fell(cke));
endmodule

// >>> sdrx_link_if.sv
// pin-level link between the memory controller and the memory end
// assumes both ends run on the same pclk; resolves the shared data pins
`timescale 1ns/1ps
interface sdrx_link_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bank_select;
  logic [11:0] mux_address_bus;
  logic        low_byte_mask;
  logic        high_byte_mask;
  logic [15:0] host_dq_out;
  logic        host_dq_oe_n;
  logic [15:0] dev_dq_out;
  logic [1:0]  dev_dq_oe_n;
  logic [15:0] shared_data_bus;

  // per byte: memory drive, else controller drive, else zero
  assign shared_data_bus[7:0] = !dev_dq_oe_n[0] ? dev_dq_out[7:0] :
                                !host_dq_oe_n ? host_dq_out[7:0] : 8'h00;
  assign shared_data_bus[15:8] = !dev_dq_oe_n[1] ? dev_dq_out[15:8] :
                                 !host_dq_oe_n ? host_dq_out[15:8] : 8'h00;

  modport host (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select, mux_address_bus,
    output low_byte_mask, high_byte_mask, host_dq_out, host_dq_oe_n,
    input  shared_data_bus
  );
  modport device (
    input  cke, cs_n, ras_n, cas_n, we_n, bank_select, mux_address_bus,
    input  low_byte_mask, high_byte_mask, shared_data_bus,
    output dev_dq_out, dev_dq_oe_n
  );
endinterface

// >>> sdrx_pkg.sv
// shared constants, command codes and burst helpers for the x16 four-bank memory link
// assumes a single 250 MHz clock shared by the controller and the memory end
package sdrx_pkg;
  localparam int DATA_W = 16;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int BANK_W = 2;
  localparam int FULL_AW = BANK_W + ROW_W + COL_W;

  // mode word fields on the address pins
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int WB_BIT = 9;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [11:0] MODE_RESET = 12'h030;

  // {select_n, row_n, col_n, write_n}
  typedef enum logic [3:0] {
    CMD_MODE      = 4'b0000,
    CMD_REFRESH   = 4'b0001,
    CMD_PRECHARGE = 4'b0010,
    CMD_ACTIVATE  = 4'b0011,
    CMD_WRITE     = 4'b0100,
    CMD_READ      = 4'b0101,
    CMD_STOP      = 4'b0110,
    CMD_NOP       = 4'b0111,
    CMD_DESELECT  = 4'b1111
  } sdrx_cmd_t;

  // timing, slowest grade, in ns
  localparam int CLK_NS = 4;
  localparam int ACT_TO_ACCESS_NS = 20;
  localparam int ROW_CYCLE_NS = 67;
  localparam int ROW_OPEN_MIN_NS = 45;
  localparam int PRECHARGE_NS = 20;
  localparam int BANK_GAP_NS = 15;
  localparam int RETENTION_MS = 64;
  localparam int REFRESH_ROWS = 4096;
  localparam int ACT_TO_ACCESS_CYC = (ACT_TO_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_CYCLE_CYC = (ROW_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_OPEN_MIN_CYC = (ROW_OPEN_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BANK_GAP_CYC = (BANK_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AFTER_PRE_CYC = (PRECHARGE_CYC > BANK_GAP_CYC) ? PRECHARGE_CYC : BANK_GAP_CYC;
  localparam int MODE_WAIT_CYC = 2;
  localparam int REFRESH_GAP_CYC = RETENTION_MS * 1000000 / (REFRESH_ROWS * CLK_NS);

  // controller register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_MODE = 3'h3;
  localparam logic [2:0] OP_SLEEP = 3'h4;
  localparam logic [2:0] OP_WAKE = 3'h5;

  function automatic logic [9:0] burst_beats(input logic [2:0] code);
    if (code == BL_FULL) begin
      return 10'h200;
    end else if (code > 3'h3) begin
      return 10'h001;
    end
    return 10'h001 << code;
  endfunction

  // full page wraps sequentially inside the row
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [COL_W-1:0] idx,
                                                 input logic [2:0] code,
                                                 input logic ilv);
    logic [COL_W-1:0] span;
    logic [COL_W-1:0] step;
    span = (code == BL_FULL) ? {COL_W{1'b1}} : COL_W'(burst_beats(code) - 10'h001);
    step = (ilv && code != BL_FULL) ? (start ^ idx) : (start + idx);
    return (start & ~span) | (step & span);
  endfunction
endpackage

// >>> tb_top.sv
// self-checking bench: controller and memory end joined by the link
// assumes design files and link checker compiled first
`timescale 1ns/1ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd;
  logic        err;
  int          error_cnt;
  int          checks_done;
  int          cycles;
  logic [11:0] modes [7] = '{12'h020, 12'h031, 12'h02a, 12'h033, 12'h03b, 12'h037, 12'h237};
  sdrx_link_if link ();
  sdrx_ctrl #(.INIT_CYCLES(4), .REFRESH_GAP(50)) sdrx_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  sdrx_device #(.STORE_AW(12)) sdrx_device_i (.pclk(pclk), .presetn(presetn), .link(link));
  sdrx_link_assertions sdrx_link_assertions_i (.pclk(pclk), .presetn(presetn), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .low_byte_mask(link.low_byte_mask), .high_byte_mask(link.high_byte_mask),
    .host_dq_oe_n(link.host_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    rd = 32'h1;
    for (int i = 0; i < 400 && rd[0] !== 1'b0; i++) apb(1'b0, sdrx_pkg::REG_STATUS, 32'h0);
    if (rd[0] !== 1'b0) begin
      error_cnt++;
      $display("BAD %0t busy never cleared", $time);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    rd = ~d;
    for (int i = 0; i < 8 && rd !== d; i++) begin
      wait_idle();
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
    end
    if (rd !== d) begin
      error_cnt++;
      $display("BAD %0t register write lost", $time);
    end
  endtask
  task automatic op(input logic [2:0] code, input int b, r, c, input logic [15:0] d);
    put(sdrx_pkg::REG_ADDR, {9'h000, 2'(b), 12'(r), 9'(c)});
    put(sdrx_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, sdrx_pkg::REG_CTRL, {29'h0, code});
    wait_idle();
    if (code == sdrx_pkg::OP_READ) apb(1'b0, sdrx_pkg::REG_RDATA, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b0, sdrx_pkg::REG_MODE, 32'h0);
    check(rd, 32'h030);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) op(sdrx_pkg::OP_WRITE, b, 3, 9'h1f0, 16'ha5c0 + b);
    for (int b = 0; b < 4; b++) begin
      op(sdrx_pkg::OP_READ, b, 3, 9'h1f0, 16'h0);
      check(rd, 32'ha5c0 + b);
    end
    $display("t_banks done");
  endtask
  task automatic t_modes();
    for (int i = 0; i < 7; i++) op(sdrx_pkg::OP_WRITE, 0, 7, 8 * i + 2, 16'h1100 + i);
    for (int i = 0; i < 7; i++) begin
      put(sdrx_pkg::REG_MODE, {20'h0, modes[i]});
      apb(1'b1, sdrx_pkg::REG_CTRL, {29'h0, sdrx_pkg::OP_MODE});
      wait_idle();
      apb(1'b0, sdrx_pkg::REG_MODE, 32'h0);
      check(rd, {20'h0, modes[i]});
      op(sdrx_pkg::OP_WRITE, 0, 7, 8 * i + 1, 16'h7e00 + i);
      op(sdrx_pkg::OP_READ, 0, 7, 8 * i + 1, 16'h0);
      check(rd, 32'h7e00 + i);
      op(sdrx_pkg::OP_READ, 0, 7, 8 * i + 2, 16'h0);
      check(rd, 32'h1100 + i);
    end
    $display("t_modes done");
  endtask
  task automatic t_sleep();
    op(sdrx_pkg::OP_WRITE, 2, 9, 5, 16'hbeef);
    apb(1'b1, sdrx_pkg::REG_CTRL, {29'h0, sdrx_pkg::OP_SLEEP});
    for (int i = 0; i < 100 && rd[1] !== 1'b1; i++) apb(1'b0, sdrx_pkg::REG_STATUS, 32'h0);
    check({31'h0, rd[1]}, 32'h1);
    check({31'h0, link.cke}, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b1, sdrx_pkg::REG_CTRL, {29'h0, sdrx_pkg::OP_WAKE});
    wait_idle();
    check({31'h0, rd[1]}, 32'h0);
    op(sdrx_pkg::OP_READ, 2, 9, 5, 16'h0);
    check(rd, 32'hbeef);
    $display("t_sleep done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_banks();
    t_modes();
    t_sleep();
    print_verdict();
  end
endmodule
